/* rtl/logic_tile_consts.vh */
// constants for the logic tile: register map, field positions, reset values, timing
`ifndef LOGIC_TILE_CONSTS_VH
`define LOGIC_TILE_CONSTS_VH
`define CELL_COUNT          8
`define GLOBAL_BUFFER_COUNT 8
`define GLOBAL_PIN_COUNT    6
`define LUT_SLOT_COUNT      4
`define REG_CTRL            8'h00
`define REG_SOURCE          8'h04
`define REG_LUT_SLOT        8'h08
`define REG_OUT_SEL         8'h0c
`define REG_STATUS          8'h10
`define REG_PIN_OUT         8'h14
`define REG_PIN_IN          8'h18
`define REG_SET_MASK        8'h1c
`define REG_LUT_BASE        8'h20
`define REG_LUT_LAST        8'h3c
`define CTRL_CFG_DONE       0
`define CTRL_SR_SYNC        1
`define CTRL_SR_USED        2
`define CTRL_CE_USED        3
`define SRC_CLK_LSB         0
`define SRC_CE_LSB          4
`define SRC_SR_LSB          8
`define SRC_ROUTING_SEL     4'h8
`define SRC_SIDE_ROUTING    3'h4
`define PIN_OE_LSB          8
`define STAT_CARRY          8
`define STAT_GLOB_RST       9
`define STAT_CFG_DONE       10
`define CTRL_RESET          4'h0
`define SOURCE_RESET        12'h888
`define LUT_SLOT_RESET      16'h0000
`define OUT_SEL_RESET       8'h00
`define SET_MASK_RESET      8'h00
`define LUT_INIT_RESET      16'h0000
`define REF_CLK_HZ          64'd50000000
`define SLOW_OSC_HZ         64'd10000
`define FAST_OSC_HZ         64'd48000000
`define NCO_SHIFT           32
`define SLOW_OSC_INC        ((`SLOW_OSC_HZ << `NCO_SHIFT) / `REF_CLK_HZ)
`define FAST_OSC_INC        ((`FAST_OSC_HZ << `NCO_SHIFT) / `REF_CLK_HZ)
`endif

/* rtl/logic_cell.v */
// one logic cell: four-input lookup table, d flip-flop and carry logic
`timescale 1ns/1ps
module logic_cell
(
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire        i_glob_rst,
  input  wire        i_tick,
  input  wire        i_ce,
  input  wire        i_sr_async,
  input  wire        i_sr_sync,
  input  wire        i_set_val,
  input  wire [15:0] i_lut_init,
  input  wire [3:0]  i_in,
  input  wire        i_carry_in,
  input  wire        i_reg_sel,
  output wire        o_out,
  output wire        o_carry_out
);
  reg  q_ff;
  wire lut_val;

  assign lut_val = i_lut_init[i_in];
  assign o_carry_out = (i_in[1] & i_in[2]) | (i_carry_in & (i_in[1] | i_in[2]));
  assign o_out = i_reg_sel ? q_ff : lut_val;

  // ticks are rising edges of the chosen tile clock seen in the reference domain
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      q_ff <= 1'b0;
    else if (i_glob_rst)
      q_ff <= 1'b0;
    else if (i_sr_async)
      q_ff <= i_set_val;
    else if (i_tick)
    begin
      if (i_sr_sync)
        q_ff <= i_set_val;
      else if (i_ce)
        q_ff <= lut_val;
      // else hold, enable low
    end
  end
endmodule // logic_cell

/* rtl/logic_tile.v */
// logic tile of eight cells with global buffer selection and avalon-mm configuration
`timescale 1ns/1ps
`include "logic_tile_consts.vh"
module logic_tile
(
  input  wire        i_ref_clk,
  input  wire        i_rst_n,
  input  wire [7:0]  i_address,
  input  wire        i_read,
  input  wire        i_write,
  input  wire [3:0]  i_byteenable,
  input  wire [31:0] i_writedata,
  output reg  [31:0] o_readdata,
  output reg         o_waitrequest,
  input  wire [5:0]  i_global_pin,
  output reg  [5:0]  o_global_pin_out,
  output reg  [5:0]  o_global_pin_oe,
  input  wire        i_route_clk,
  input  wire        i_route_ce,
  input  wire        i_route_sr,
  input  wire [31:0] i_lut_in,
  input  wire        i_carry_chain_in,
  output reg         o_carry_chain_out,
  output reg  [7:0]  o_cell_out,
  output reg  [7:0]  o_slow_osc_clk,
  output reg         o_fast_osc_clk
);
  localparam [63:0] SLOW_INC_W = `SLOW_OSC_INC;
  localparam [63:0] FAST_INC_W = `FAST_OSC_INC;
  localparam [31:0] SLOW_INC   = SLOW_INC_W[31:0];
  localparam [31:0] FAST_INC   = FAST_INC_W[31:0];

  // byte-lane merge used by every writable register
  function [31:0] merge_be;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  be;
    integer k;
    begin
      merge_be = old_val;
      for (k = 0; k < 4; k = k + 1)
        if (be[k])
          merge_be[k*8 +: 8] = new_val[k*8 +: 8];
    end
  endfunction

  // picks buffer 2*sel+side from the global buffers, or routing
  function pick_side;
    input [7:0] global_buffer;
    input [2:0] sel;
    input       odd;
    input       route;
    begin
      if (sel == `SRC_SIDE_ROUTING)
        pick_side = route;
      else if (sel[2])
        pick_side = 1'b0;
      else
        pick_side = global_buffer[{sel[1:0], odd}];
    end
  endfunction

  reg  [3:0]  ctrl_ff;
  reg  [11:0] source_ff;
  reg  [15:0] lut_slot_ff;
  reg  [7:0]  out_sel_ff;
  reg  [7:0]  set_mask_ff;
  reg  [13:0] pin_out_ff;
  reg  [15:0] lut_init_ff [0:7];
  reg  [31:0] slow_acc_ff;
  reg  [31:0] fast_acc_ff;
  reg  [5:0]  pin_s1_ff;
  reg  [5:0]  pin_s2_ff;
  reg  [5:0]  pin_s3_ff;
  reg  [5:0]  pin_level_ff;
  reg         cfg_done_d_ff;
  reg         glob_rst_ff;
  reg         tile_clk_d_ff;
  reg  [31:0] nxt_readdata;
  reg  [31:0] lut_inputs;
  wire [7:0]  global_buffer;
  wire [3:0]  clk_sel;
  wire        tile_clk;
  wire        tick;
  wire        ce_src;
  wire        sr_src;
  wire        ce_eff;
  wire        sr_act;
  wire        sr_sync_mode;
  wire        access;
  wire        cfg_done;
  wire [7:0]  cell_out;
  wire [8:0]  carry;
  wire [5:0]  pin_is_clk;
  wire [31:0] wr_word;
  integer     i;
  integer     s;
  integer     p;
  integer     r;

  assign access = (i_read | i_write) & o_waitrequest;
  assign cfg_done = ctrl_ff[`CTRL_CFG_DONE];
  assign sr_sync_mode = ctrl_ff[`CTRL_SR_SYNC];
  // old word comes from the read mux, so bits above a field merge in as zero
  assign wr_word = merge_be(nxt_readdata, i_writedata, i_byteenable);

  // buffer map: pins g0..g3 to 0..3, oscillators to 4 and 5, pins g4 g5 to 6 and 7
  assign global_buffer = {pin_level_ff[5:4], fast_acc_ff[31], slow_acc_ff[31], pin_level_ff[3:0]};

  // tile clock select; 8 and above take routing
  assign clk_sel = source_ff[`SRC_CLK_LSB +: 4];
  assign tile_clk = clk_sel[3] ? i_route_clk : global_buffer[clk_sel[2:0]];
  assign tick = tile_clk & ~tile_clk_d_ff;

  assign ce_src = pick_side(global_buffer, source_ff[`SRC_CE_LSB +: 3], 1'b1, i_route_ce);
  assign sr_src = pick_side(global_buffer, source_ff[`SRC_SR_LSB +: 3], 1'b0, i_route_sr);
  assign ce_eff = ctrl_ff[`CTRL_CE_USED] ? ce_src : 1'b1;
  assign sr_act = ctrl_ff[`CTRL_SR_USED] & sr_src;

  // a pin that feeds the tile clock cannot be an output at the same time
  assign pin_is_clk[0] = ~clk_sel[3] & (clk_sel[2:0] == 3'd0);
  assign pin_is_clk[1] = ~clk_sel[3] & (clk_sel[2:0] == 3'd1);
  assign pin_is_clk[2] = ~clk_sel[3] & (clk_sel[2:0] == 3'd2);
  assign pin_is_clk[3] = ~clk_sel[3] & (clk_sel[2:0] == 3'd3);
  assign pin_is_clk[4] = ~clk_sel[3] & (clk_sel[2:0] == 3'd6);
  assign pin_is_clk[5] = ~clk_sel[3] & (clk_sel[2:0] == 3'd7);

  // up to four global buffers replace lut input k in every cell
  always @*
  begin
    lut_inputs = i_lut_in;
    for (s = 0; s < `LUT_SLOT_COUNT; s = s + 1)
      if (lut_slot_ff[s*4 + 3])
        for (i = 0; i < `CELL_COUNT; i = i + 1)
          lut_inputs[i*4 + s] = global_buffer[lut_slot_ff[s*4 +: 3]];
  end

  assign carry[0] = i_carry_chain_in;

  genvar c;
  generate
    for (c = 0; c < `CELL_COUNT; c = c + 1)
    begin : g_cell
      logic_cell u_cell
      (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_glob_rst  (glob_rst_ff),
        .i_tick      (tick),
        .i_ce        (ce_eff),
        .i_sr_async  (sr_act & ~sr_sync_mode),
        .i_sr_sync   (sr_act & sr_sync_mode),
        .i_set_val   (set_mask_ff[c]),
        .i_lut_init  (lut_init_ff[c]),
        .i_in        (lut_inputs[c*4 +: 4]),
        .i_carry_in  (carry[c]),
        .i_reg_sel   (out_sel_ff[c]),
        .o_out       (cell_out[c]),
        .o_carry_out (carry[c+1])
      );
    end
  endgenerate

  // global reset: held while configuration is open and two cycles after it closes
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_done_d_ff <= 1'b0;
      glob_rst_ff <= 1'b1;
    end
    else
    begin
      cfg_done_d_ff <= cfg_done;
      glob_rst_ff <= ~cfg_done | ~cfg_done_d_ff;
    end
  end

  // pins pass three flops; the level moves only once stages two and three agree
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pin_s1_ff <= 6'h00;
      pin_s2_ff <= 6'h00;
      pin_s3_ff <= 6'h00;
      pin_level_ff <= 6'h00;
    end
    else
    begin
      pin_s1_ff <= i_global_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
      for (p = 0; p < `GLOBAL_PIN_COUNT; p = p + 1)
        if (pin_s2_ff[p] == pin_s3_ff[p])
          pin_level_ff[p] <= pin_s3_ff[p];
    end
  end

  // oscillators as phase accumulators; 48 mhz from a 50 mhz clock jitters by one period
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      slow_acc_ff <= 32'h00000000;
      fast_acc_ff <= 32'h00000000;
    end
    else
    begin
      slow_acc_ff <= slow_acc_ff + SLOW_INC;
      fast_acc_ff <= fast_acc_ff + FAST_INC;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tile_clk_d_ff <= 1'b0;
    else
      tile_clk_d_ff <= tile_clk;
  end

  // read mux, captured on the cycle the request is first seen
  always @*
  begin
    nxt_readdata = 32'h00000000;
    case (i_address)
      `REG_CTRL:     nxt_readdata[3:0] = ctrl_ff;
      `REG_SOURCE:   nxt_readdata[11:0] = source_ff;
      `REG_LUT_SLOT: nxt_readdata[15:0] = lut_slot_ff;
      `REG_OUT_SEL:  nxt_readdata[7:0] = out_sel_ff;
      `REG_STATUS:
      begin
        nxt_readdata[7:0] = cell_out;
        nxt_readdata[`STAT_CARRY] = carry[8];
        nxt_readdata[`STAT_GLOB_RST] = glob_rst_ff;
        nxt_readdata[`STAT_CFG_DONE] = cfg_done;
      end
      `REG_PIN_OUT:  nxt_readdata[13:0] = pin_out_ff;
      `REG_PIN_IN:   nxt_readdata[5:0] = pin_level_ff;
      `REG_SET_MASK: nxt_readdata[7:0] = set_mask_ff;
      default:
      begin
        if (i_address >= `REG_LUT_BASE && i_address <= `REG_LUT_LAST && i_address[1:0] == 2'b00)
          nxt_readdata[15:0] = lut_init_ff[i_address[4:2]];
      end
    endcase
  end

  // one wait cycle: waitrequest drops on the edge after the request appears
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h00000000;
    end
    else if (access)
    begin
      o_waitrequest <= 1'b0;
      if (i_read)
        o_readdata <= nxt_readdata;
    end
    else
      o_waitrequest <= 1'b1;
  end

  // writes land on the edge that samples waitrequest low; unmapped writes vanish
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_ff <= `CTRL_RESET;
      source_ff <= `SOURCE_RESET;
      lut_slot_ff <= `LUT_SLOT_RESET;
      out_sel_ff <= `OUT_SEL_RESET;
      set_mask_ff <= `SET_MASK_RESET;
      pin_out_ff <= 14'h0000;
      for (r = 0; r < `CELL_COUNT; r = r + 1)
        lut_init_ff[r] <= `LUT_INIT_RESET;
    end
    else if (i_write && !o_waitrequest)
    begin
      case (i_address)
        `REG_CTRL:     ctrl_ff <= wr_word[3:0];
        `REG_SOURCE:   source_ff <= wr_word[11:0];
        `REG_LUT_SLOT: lut_slot_ff <= wr_word[15:0];
        `REG_OUT_SEL:  out_sel_ff <= wr_word[7:0];
        `REG_PIN_OUT:  pin_out_ff <= wr_word[13:0] & 14'h3f3f;
        `REG_SET_MASK: set_mask_ff <= wr_word[7:0];
        default:
        begin
          if (i_address >= `REG_LUT_BASE && i_address <= `REG_LUT_LAST && i_address[1:0] == 2'b00)
            lut_init_ff[i_address[4:2]] <= wr_word[15:0];
        end
      endcase
    end
  end

  // registered user outputs
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cell_out <= 8'h00;
      o_carry_chain_out <= 1'b0;
      o_global_pin_out <= 6'h00;
      o_global_pin_oe <= 6'h00;
      o_slow_osc_clk <= 8'h00;
      o_fast_osc_clk <= 1'b0;
    end
    else
    begin
      o_cell_out <= cell_out;
      o_carry_chain_out <= carry[8];
      o_global_pin_out <= pin_out_ff[5:0];
      o_global_pin_oe <= pin_out_ff[`PIN_OE_LSB +: 6] & ~pin_is_clk;
      o_slow_osc_clk <= {8{slow_acc_ff[31]}};
      o_fast_osc_clk <= fast_acc_ff[31];
    end
  end
endmodule // logic_tile

/* test/tile_fabric.sv */
// routing-fabric model: turns a tick request of one or two cycles into one clean route clock pulse
`timescale 1ns/1ps
module tile_fabric
(
  input  wire  i_ref_clk,
  input  wire  i_rst_n,
  input  wire  i_tick,
  output logic o_route_clk
);
  // high one cycle then low one cycle, so a held request never merges two ticks
  always @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_route_clk <= 1'b0;
    else
      o_route_clk <= i_tick & !o_route_clk;
  end
endmodule // tile_fabric

/* test/logic_tile_assertions.sv */
// checker of bus handshake, pin outputs and oscillator outputs of the logic tile
`timescale 1ns/1ps
module logic_tile_assertions
(
  input wire        i_ref_clk,
  input wire        i_rst_n,
  input wire        i_read,
  input wire        i_write,
  input wire [31:0] o_readdata,
  input wire        o_waitrequest,
  input wire [5:0]  o_global_pin_out,
  input wire [5:0]  o_global_pin_oe,
  input wire [7:0]  o_slow_osc_clk,
  input wire        o_fast_osc_clk
);
  // a write takes effect on the edge that samples waitrequest low
  wire write_taken = i_write & ~o_waitrequest;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence taken_s;
    (i_read || i_write) && o_waitrequest;
  endsequence
  sequence answer_s;
    !o_waitrequest ##1 o_waitrequest;
  endsequence
  a_wait_one: assert property (taken_s |=> answer_s)
    else $error("request not answered after one wait cycle");
  a_wait_pulse: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_idle: assert property (!i_read && !i_write && o_waitrequest |=> o_waitrequest)
    else $error("waitrequest dropped with no request");
  // read data may only move on the edge that takes a read
  a_read_hold: assert property (!(i_read && o_waitrequest) |=> $stable(o_readdata))
    else $error("read data changed without a read");
  // register lands at the write edge, the output flop one edge later
  a_pin_write: assert property ($changed(o_global_pin_oe) || $changed(o_global_pin_out)
    |-> $past(write_taken, 2))
    else $error("pin drive changed without a write");
  a_osc_same: assert property (o_slow_osc_clk == {8{o_slow_osc_clk[0]}})
    else $error("slow oscillator copies disagree");
  a_slow_hold: assert property ($changed(o_slow_osc_clk[0]) |=> $stable(o_slow_osc_clk[0])[*8])
    else $error("slow oscillator toggles too fast");
  // sampled at 50 mhz the fast source aliases, but it must still move often
  a_fast_live: assert property (1'b1 |-> ##[1:30] $changed(o_fast_osc_clk))
    else $error("fast oscillator stalled");
endmodule // logic_tile_assertions
bind logic_tile logic_tile_assertions chk_u
(
  .i_ref_clk        (i_ref_clk),
  .i_rst_n          (i_rst_n),
  .i_read           (i_read),
  .i_write          (i_write),
  .o_readdata       (o_readdata),
  .o_waitrequest    (o_waitrequest),
  .o_global_pin_out (o_global_pin_out),
  .o_global_pin_oe  (o_global_pin_oe),
  .o_slow_osc_clk   (o_slow_osc_clk),
  .o_fast_osc_clk   (o_fast_osc_clk)
);

/* test/logic_tile_test.sv */
// self-checking bench of the logic tile
`timescale 1ns/1ps
`include "logic_tile_consts.vh"
module logic_tile_test;
  typedef struct packed {logic [15:0] init; logic [31:0] lin; logic cin; logic [7:0] cells; logic cout;} row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [5:0]  pins = 6'h00;
  logic        tick_req = 1'b0;
  logic        route_ce = 1'b0;
  logic        route_sr = 1'b0;
  logic [31:0] lut_in = 32'h0;
  logic        cin = 1'b0;
  wire  [31:0] readdata;
  wire         waitrequest;
  wire  [5:0]  pin_out;
  wire  [5:0]  pin_oe;
  wire         route_clk;
  wire         carry_out;
  wire  [7:0]  cell_out;
  wire  [7:0]  slow_osc;
  wire         fast_osc;
  int          fail_count = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          half;
  logic        lv;
  logic [31:0] q;
  row_t        rows [7] = '{
    '{16'h8000, 32'hffffffff, 1'b0, 8'hff, 1'b1}, '{16'h6996, 32'h11111111, 1'b1, 8'hff, 1'b0},
    '{16'h6996, 32'h33333333, 1'b1, 8'h00, 1'b1}, '{16'h0001, 32'h00000000, 1'b0, 8'hff, 1'b0},
    '{16'h0001, 32'h22222222, 1'b0, 8'h00, 1'b0}, '{16'h4000, 32'heeeeeeee, 1'b0, 8'hff, 1'b1},
    '{16'h4000, 32'h66666666, 1'b1, 8'h00, 1'b1}};
  always #10 clk = ~clk;
  logic_tile dut_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_address(addr), .i_read(rd), .i_write(wr),
    .i_byteenable(4'hf), .i_writedata(wdata), .o_readdata(readdata), .o_waitrequest(waitrequest),
    .i_global_pin(pins), .o_global_pin_out(pin_out), .o_global_pin_oe(pin_oe), .i_route_clk(route_clk),
    .i_route_ce(route_ce), .i_route_sr(route_sr), .i_lut_in(lut_in), .i_carry_chain_in(cin),
    .o_carry_chain_out(carry_out), .o_cell_out(cell_out), .o_slow_osc_clk(slow_osc), .o_fast_osc_clk(fast_osc));
  tile_fabric fab_u (.i_ref_clk(clk), .i_rst_n(rst_n), .i_tick(tick_req), .o_route_clk(route_clk));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low; q takes read data at that edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task set_lut(input logic [15:0] v);
    for (int c = 0; c < 8; c++) bus(1'b1, `REG_LUT_BASE + 8'(4 * c), {16'h0, v});
  endtask
  task tick;
    @(posedge clk);
    tick_req <= 1'b1;
    repeat (2) @(posedge clk);
    tick_req <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ceiling well above the slow oscillator periods that dominate the run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      test_done;
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    chk(32'(waitrequest), 32'h1);
    chk(32'(cell_out), 32'h0);
    rst_n <= 1'b1;
    bus(1'b0, `REG_CTRL, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, `REG_SOURCE, 32'h0);
    chk(q, 32'h888);
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h1);
    // global reset outlasts cfg_done by two cycles, so let it clear first
    repeat (2) @(posedge clk);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk(32'(q[10:9]), 32'h2);
    $display("reset test done");
    foreach (rows[i])
    begin
      set_lut(rows[i].init);
      lut_in <= rows[i].lin;
      cin <= rows[i].cin;
      repeat (4) @(posedge clk);
      chk(32'(cell_out), 32'(rows[i].cells));
      chk(32'(carry_out), 32'(rows[i].cout));
    end
    $display("table test done");
    // clock, enable and set/reset all taken from routing
    bus(1'b1, `REG_SOURCE, 32'h448);
    bus(1'b1, `REG_OUT_SEL, 32'hff);
    set_lut(16'haaaa);
    lut_in <= 32'h11111111;
    tick;
    chk(32'(cell_out), 32'hff);
    bus(1'b1, `REG_CTRL, 32'h9);
    lut_in <= 32'h0;
    tick;
    chk(32'(cell_out), 32'hff);
    route_ce <= 1'b1;
    tick;
    chk(32'(cell_out), 32'h0);
    bus(1'b1, `REG_SET_MASK, 32'h0f);
    bus(1'b1, `REG_CTRL, 32'hd);
    route_ce <= 1'b0;
    route_sr <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(cell_out), 32'h0f);
    route_sr <= 1'b0;
    bus(1'b1, `REG_SET_MASK, 32'hf0);
    bus(1'b1, `REG_CTRL, 32'hf);
    route_sr <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'(cell_out), 32'h0f);
    tick;
    chk(32'(cell_out), 32'hf0);
    bus(1'b1, `REG_CTRL, 32'h9);
    route_ce <= 1'b1;
    lut_in <= 32'h11111111;
    tick;
    chk(32'(cell_out), 32'hff);
    route_sr <= 1'b0;
    bus(1'b1, `REG_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    chk(32'(cell_out), 32'h0);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk(32'(q[9]), 32'h1);
    $display("flop test done");
    bus(1'b1, `REG_PIN_OUT, 32'h3f15);
    repeat (3) @(posedge clk);
    chk(32'(pin_out), 32'h15);
    chk(32'(pin_oe), 32'h3f);
    bus(1'b1, `REG_SOURCE, 32'h880);
    repeat (3) @(posedge clk);
    chk(32'(pin_oe), 32'h3e);
    pins <= 6'h2a;
    repeat (6) @(posedge clk);
    bus(1'b0, `REG_PIN_IN, 32'h0);
    chk(q, 32'h2a);
    $display("pin test done");
    // enable from buffer 1 (pin 1 high), set/reset from buffer 2 (pin 2)
    bus(1'b1, `REG_SOURCE, 32'h108);
    bus(1'b1, `REG_CTRL, 32'hd);
    tick;
    chk(32'(cell_out), 32'hff);
    pins <= 6'h15;
    repeat (8) @(posedge clk);
    chk(32'(cell_out), 32'hf0);
    $display("select test done");
    lv = slow_osc[0];
    while (slow_osc[0] === lv) @(posedge clk);
    half = 0;
    lv = slow_osc[0];
    while (slow_osc[0] === lv)
    begin
      @(posedge clk);
      half++;
    end
    chk(32'(half >= 2495 && half <= 2505), 32'h1);
    bus(1'b1, `REG_CTRL, 32'h1);
    bus(1'b1, `REG_OUT_SEL, 32'h0);
    bus(1'b1, `REG_LUT_SLOT, 32'hc);
    lv = slow_osc[0];
    while (slow_osc[0] === lv) @(posedge clk);
    repeat (10) @(posedge clk);
    chk(32'(cell_out), 32'({8{~lv}}));
    $display("oscillator test done");
    test_done;
  end
endmodule // logic_tile_test
